// ==== common/ebh_defs.vh ====
`ifndef EBH_DEFS_VH
`define EBH_DEFS_VH

// Clock and timing
`define EBH_CLK_KHZ        25000
`define EBH_ACK_TMO_MS     50
`define EBH_DST_ACK_TMO_MS 950
`define EBH_DST_TMO_MS     1000

// Register byte offsets
`define EBH_OFS_CTRL   6'h00
`define EBH_OFS_CMD    6'h04
`define EBH_OFS_CMDARG 6'h08
`define EBH_OFS_TMOUT  6'h0C
`define EBH_OFS_BLKSIZ 6'h10
`define EBH_OFS_BYTCNT 6'h14
`define EBH_OFS_RINT   6'h18
`define EBH_OFS_IDSTS  6'h1C
`define EBH_OFS_WMARK  6'h20
`define EBH_OFS_STATUS 6'h24
`define EBH_OFS_DATA   6'h28
`define EBH_OFS_DBASE  6'h2C
`define EBH_OFS_DCOUNT 6'h30
`define EBH_OFS_DCLOSE 6'h34

// Control fields
`define EBH_CTRL_INT_EN  0
`define EBH_CTRL_USE_DMA 1

// Command word fields
`define EBH_CMD_START    31
`define EBH_CMD_DIS_BOOT 26
`define EBH_CMD_EXP_ACK  25
`define EBH_CMD_BOOT_EN  24
`define EBH_CMD_DATA_EXP 9

// Raw status fields
`define EBH_RINT_CMD_DONE  2
`define EBH_RINT_XFER_OVER 3
`define EBH_RINT_RX_REQ    4
`define EBH_RINT_RD_TMO    9
`define EBH_RINT_OVERRUN   11
`define EBH_RINT_START_ERR 13
`define EBH_RINT_END_ERR   15
`define EBH_RINT_ACK_RCVD  16
`define EBH_RINT_DATA_ST   17

// DMA status fields
`define EBH_IDS_RX_DONE   1
`define EBH_IDS_DESC_UNAV 4
`define EBH_IDS_CARD_ERR  5

// Reset values
`define EBH_CTRL_RST   2'h0
`define EBH_TMOUT_RST  24'hFFFFFF
`define EBH_BLKSIZ_RST 16'h0200
`define EBH_BYTCNT_RST 32'h00000200
`define EBH_WMARK_RST  5'h08

// Link framing and DMA buffer end
`define EBH_CMD_BITS   6'd48
`define EBH_CMD_BODY   6'd40
`define EBH_CMD_CRCEND 6'd47
`define EBH_CRC7_POLY  7'h09
`define EBH_ACK_PAT    3'h2
`define EBH_ACK_LAST   6'd3
`define EBH_DCRC_LAST  6'd16
`define EBH_DESC_LAST  9'h1FC

`endif

// ==== hw/ebh_sync.v ====
module ebh_sync #(
  parameter W = 2
) (
  // Clock and reset
  input  wire         clk,
  input  wire         rst,
  // Data
  input  wire [W-1:0] d,
  output reg  [W-1:0] q
);
  reg [W-1:0] meta_q;

  always @(posedge clk) begin
    if (rst) begin
      meta_q <= {W{1'b0}};
      q      <= {W{1'b0}};
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule // ebh_sync

// ==== hw/ebh_ram.v ====
module ebh_ram #(
  parameter AW = 4,
  parameter DW = 32
) (
  // Clock
  input  wire          clk,
  // Write port
  input  wire          we,
  input  wire [AW-1:0] waddr,
  input  wire [DW-1:0] wdata,
  // Read port
  input  wire [AW-1:0] raddr,
  output reg  [DW-1:0] rdata
);
  reg [DW-1:0] mem [0:(1<<AW)-1];

  always @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule // ebh_ram

// ==== hw/ebh_boot.v ====
// The Avalon-MM interface to the registers and the address map were chosen for this implementation.
`include "ebh_defs.vh"
module ebh_boot #(
  parameter [24:0] ACK_TMO_CYC     = `EBH_ACK_TMO_MS * `EBH_CLK_KHZ,
  parameter [24:0] DST_ACK_TMO_CYC = `EBH_DST_ACK_TMO_MS * `EBH_CLK_KHZ,
  parameter [24:0] DST_TMO_CYC     = `EBH_DST_TMO_MS * `EBH_CLK_KHZ
) (
  // Clock and reset
  input  wire        mclk,
  input  wire        sys_rst,
  // Avalon-MM slave
  input  wire [5:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  output reg  [31:0] avs_readdata,
  output reg         avs_waitrequest,
  // Card link
  input  wire        card_clk,
  input  wire        cmd_in,
  output reg         cmd_out,
  output reg         cmd_oe_n,
  input  wire        dat0_in,
  // DMA write to system memory
  output reg         dma_wr_valid,
  output reg  [31:0] dma_wr_addr,
  output reg  [31:0] dma_wr_data,
  input  wire        dma_wr_ready
);
  localparam S_IDLE = 3'h0;
  localparam S_CMD  = 3'h1;
  localparam S_WACK = 3'h2;
  localparam S_ACK  = 3'h3;
  localparam S_WST  = 3'h4;
  localparam S_DATA = 3'h5;
  localparam S_CRC  = 3'h6;

  // Register file
  reg [1:0]  ctrl_q;
  reg [31:0] cmd_q, cmdarg_q, bytcnt_q, dbase_q, rdmux;
  reg [23:0] tmout_q;
  reg [15:0] blksiz_q, dcount_q, dclosed_q;
  reg [17:0] rint_q, rint_set;
  reg [5:0]  ids_q, ids_set;
  reg [4:0]  wmark_q;
  reg [1:0]  ph_q;
  reg        cmd_go_q, drst_q;
  // Link state
  reg [2:0]  st_q;
  reg [5:0]  bit_q;
  reg [39:0] sr_q;
  reg [6:0]  crc_q;
  reg [2:0]  pat_q;
  reg [24:0] tmo_q;
  reg [23:0] acc_q;
  reg [18:0] blk_q;
  reg [31:0] rxb_q, word_q, push_data_q;
  reg [4:0]  wbit_q;
  reg        boot_q, exp_q, first_q, late_q, xend_q, push_q, cclk_p_q;
  reg        ev_done_q, ev_over_q, ev_rdtmo_q, ev_serr_q, ev_eerr_q;
  reg        ev_ack_q, ev_dst_q, ev_tmo_q;
  // FIFO and DMA
  reg [3:0]  wp_q, rp_q;
  reg [4:0]  lvl_q;
  reg [8:0]  off_q;
  reg        rxd_pend_q, ev_rxd_q, ev_unav_q;

  wire [1:0]  sync_q;
  wire [31:0] ram_rdata;
  wire        cclk_s   = sync_q[1];
  wire        dat0_s   = sync_q[0];
  wire        cclk_r   = cclk_s & ~cclk_p_q;
  wire        cclk_f   = ~cclk_s & cclk_p_q;
  wire        use_dma  = ctrl_q[`EBH_CTRL_USE_DMA];
  wire        acc_go   = (ph_q == 2'h2);
  wire        wr_go    = acc_go & avs_write;
  wire        push_ok  = push_q & (lvl_q != 5'h10);
  wire [4:0]  wm_eff   = (wmark_q == 5'h0) ? 5'h1 : wmark_q;
  wire        sw_pop   = acc_go & avs_read & (avs_address == `EBH_OFS_DATA)
                         & ~use_dma & (lvl_q != 5'h0);
  wire        dma_pop  = use_dma & ~dma_wr_valid & (lvl_q != 5'h0)
                         & ((lvl_q >= wm_eff) | xend_q);
  wire        pop      = sw_pop | dma_pop;
  wire [18:0] blk_last = {blksiz_q, 3'h0} - 19'h1;
  wire [24:0] dst_lim  = exp_q ? DST_ACK_TMO_CYC : DST_TMO_CYC;
  wire        desc_ok  = dclosed_q < dcount_q;

  ebh_sync #(.W(2)) u_sync (
    .clk (mclk),
    .rst (sys_rst),
    .d   ({card_clk, dat0_in}),
    .q   (sync_q)
  );

  ebh_ram #(.AW(4), .DW(32)) u_ram (
    .clk   (mclk),
    .we    (push_ok),
    .waddr (wp_q),
    .wdata (push_data_q),
    .raddr (rp_q),
    .rdata (ram_rdata)
  );

  // Flag set vectors; a set in the clearing cycle survives
  always @* begin
    rint_set = 18'h0;
    rint_set[`EBH_RINT_CMD_DONE]  = ev_done_q;
    rint_set[`EBH_RINT_XFER_OVER] = ev_over_q;
    rint_set[`EBH_RINT_RX_REQ]    = ~use_dma & (lvl_q >= wm_eff);
    rint_set[`EBH_RINT_RD_TMO]    = ev_rdtmo_q;
    rint_set[`EBH_RINT_OVERRUN]   = push_q & ~push_ok;
    rint_set[`EBH_RINT_START_ERR] = ev_serr_q;
    rint_set[`EBH_RINT_END_ERR]   = ev_eerr_q;
    rint_set[`EBH_RINT_ACK_RCVD]  = ev_ack_q;
    rint_set[`EBH_RINT_DATA_ST]   = ev_dst_q;
    ids_set = 6'h0;
    ids_set[`EBH_IDS_RX_DONE]   = ev_rxd_q;
    ids_set[`EBH_IDS_DESC_UNAV] = ev_unav_q;
    ids_set[`EBH_IDS_CARD_ERR]  = ev_tmo_q & use_dma;
  end

  always @* begin
    case (avs_address)
      `EBH_OFS_CTRL:   rdmux = {30'h0, ctrl_q};
      `EBH_OFS_CMD:    rdmux = {cmd_go_q | (st_q != S_IDLE), cmd_q[30:0]};
      `EBH_OFS_CMDARG: rdmux = cmdarg_q;
      `EBH_OFS_TMOUT:  rdmux = {8'h0, tmout_q};
      `EBH_OFS_BLKSIZ: rdmux = {16'h0, blksiz_q};
      `EBH_OFS_BYTCNT: rdmux = bytcnt_q;
      `EBH_OFS_RINT:   rdmux = {14'h0, rint_q};
      `EBH_OFS_IDSTS:  rdmux = {26'h0, ids_q};
      `EBH_OFS_WMARK:  rdmux = {27'h0, wmark_q};
      `EBH_OFS_STATUS: rdmux = {24'h0, lvl_q, st_q};
      `EBH_OFS_DATA:   rdmux = ram_rdata;
      `EBH_OFS_DBASE:  rdmux = dbase_q;
      `EBH_OFS_DCOUNT: rdmux = {16'h0, dcount_q};
      `EBH_OFS_DCLOSE: rdmux = {16'h0, dclosed_q};
      default:         rdmux = 32'h0;
    endcase
  end

  // Bus slave: two wait cycles give the FIFO read port time to settle
  always @(posedge mclk) begin
    if (sys_rst) begin
      ph_q <= 2'h0;
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0;
      ctrl_q <= `EBH_CTRL_RST;
      cmd_q <= 32'h0;
      cmdarg_q <= 32'h0;
      tmout_q <= `EBH_TMOUT_RST;
      blksiz_q <= `EBH_BLKSIZ_RST;
      bytcnt_q <= `EBH_BYTCNT_RST;
      wmark_q <= `EBH_WMARK_RST;
      dbase_q <= 32'h0;
      dcount_q <= 16'h0;
      rint_q <= 18'h0;
      ids_q <= 6'h0;
      cmd_go_q <= 1'b0;
      drst_q <= 1'b0;
    end else begin
      cmd_go_q <= 1'b0;
      drst_q <= 1'b0;
      if (ph_q == 2'h0 && (avs_read || avs_write)) begin
        ph_q <= 2'h1;
      end else if (ph_q == 2'h1) begin
        ph_q <= 2'h2;
        avs_waitrequest <= 1'b0;
        avs_readdata <= avs_read ? rdmux : 32'h0;
      end else if (ph_q == 2'h2) begin
        ph_q <= 2'h0;
        avs_waitrequest <= 1'b1;
      end
      if (wr_go) begin
        case (avs_address)
          `EBH_OFS_CTRL:   ctrl_q <= avs_writedata[1:0];
          `EBH_OFS_CMD: begin
            cmd_q <= avs_writedata;
            cmd_go_q <= avs_writedata[`EBH_CMD_START];
          end
          `EBH_OFS_CMDARG: cmdarg_q <= avs_writedata;
          `EBH_OFS_TMOUT:  tmout_q <= avs_writedata[23:0];
          `EBH_OFS_BLKSIZ: blksiz_q <= avs_writedata[15:0];
          `EBH_OFS_BYTCNT: bytcnt_q <= avs_writedata;
          `EBH_OFS_WMARK:  wmark_q <= avs_writedata[4:0];
          `EBH_OFS_DBASE:  dbase_q <= avs_writedata;
          `EBH_OFS_DCOUNT: begin
            dcount_q <= avs_writedata[15:0];
            drst_q <= 1'b1;
          end
          default: ;
        endcase
      end
      rint_q <= (rint_q & ~((wr_go && avs_address == `EBH_OFS_RINT) ?
                avs_writedata[17:0] : 18'h0)) | rint_set;
      ids_q <= (ids_q & ~((wr_go && avs_address == `EBH_OFS_IDSTS) ?
               avs_writedata[5:0] : 6'h0)) | ids_set;
    end
  end

  // Card link sequencer; a new command aborts whatever runs
  always @(posedge mclk) begin
    if (sys_rst) begin
      st_q <= S_IDLE;
      cclk_p_q <= 1'b0;
      cmd_out <= 1'b1;
      cmd_oe_n <= 1'b1;
      bit_q <= 6'h0;
      sr_q <= 40'h0;
      crc_q <= 7'h0;
      pat_q <= 3'h0;
      tmo_q <= 25'h0;
      acc_q <= 24'h0;
      blk_q <= 19'h0;
      rxb_q <= 32'h0;
      word_q <= 32'h0;
      wbit_q <= 5'h0;
      push_data_q <= 32'h0;
      {boot_q, exp_q, first_q, late_q, xend_q, push_q} <= 6'h0;
      {ev_done_q, ev_over_q, ev_rdtmo_q, ev_serr_q} <= 4'h0;
      {ev_eerr_q, ev_ack_q, ev_dst_q, ev_tmo_q} <= 4'h0;
    end else begin
      cclk_p_q <= cclk_s;
      {ev_done_q, ev_over_q, ev_rdtmo_q, ev_serr_q} <= 4'h0;
      {ev_eerr_q, ev_ack_q, ev_dst_q, ev_tmo_q, push_q} <= 5'h0;
      tmo_q <= tmo_q + 25'h1;
      if (cmd_go_q) begin
        st_q <= S_CMD;
        sr_q <= {2'b01, cmd_q[5:0], cmdarg_q};
        crc_q <= 7'h0;
        bit_q <= 6'h0;
        boot_q <= cmd_q[`EBH_CMD_BOOT_EN] & ~cmd_q[`EBH_CMD_DIS_BOOT];
        exp_q <= cmd_q[`EBH_CMD_EXP_ACK];
        tmo_q <= 25'h0;
        {rxb_q, blk_q, wbit_q} <= 56'h0;
        {first_q, late_q, xend_q} <= 3'b100;
      end else begin
        case (st_q)
          S_CMD: if (cclk_f) begin
            bit_q <= bit_q + 6'h1;
            cmd_oe_n <= 1'b0;
            if (bit_q == `EBH_CMD_BITS) begin
              cmd_oe_n <= 1'b1;
              cmd_out <= 1'b1;
              if (boot_q) begin
                st_q <= exp_q ? S_WACK : S_WST;
              end else begin
                st_q <= S_IDLE;
                ev_done_q <= 1'b1;
              end
            end else if (bit_q < `EBH_CMD_BODY) begin
              cmd_out <= sr_q[39];
              sr_q <= {sr_q[38:0], 1'b0};
              crc_q <= {crc_q[5:0], 1'b0} ^
                       ((sr_q[39] ^ crc_q[6]) ? `EBH_CRC7_POLY : 7'h0);
            end else if (bit_q < `EBH_CMD_CRCEND) begin
              cmd_out <= crc_q[6];
              crc_q <= {crc_q[5:0], 1'b0};
            end else begin
              cmd_out <= 1'b1;
            end
          end
          S_WACK: begin
            if (tmo_q == ACK_TMO_CYC) begin
              st_q <= S_IDLE;
              boot_q <= 1'b0;
              ev_tmo_q <= 1'b1;
            end else if (cclk_r && !dat0_s) begin
              st_q <= S_ACK;
              bit_q <= 6'h0;
            end
          end
          S_ACK: if (cclk_r) begin
            bit_q <= bit_q + 6'h1;
            pat_q <= {pat_q[1:0], dat0_s};
            if (bit_q == `EBH_ACK_LAST) begin
              ev_ack_q <= (pat_q == `EBH_ACK_PAT) & dat0_s;
              ev_eerr_q <= ~dat0_s;
              st_q <= S_WST;
              tmo_q <= 25'h0;
            end
          end
          S_WST: begin
            if (cclk_r) begin
              acc_q <= acc_q + 24'h1;
            end
            if (first_q && tmo_q == dst_lim) begin
              st_q <= S_IDLE;
              boot_q <= 1'b0;
              ev_tmo_q <= 1'b1;
            end else if (cclk_r && !dat0_s) begin
              st_q <= S_DATA;
              blk_q <= 19'h0;
              ev_dst_q <= first_q;
              ev_serr_q <= late_q;
              late_q <= 1'b0;
            end else if (!first_q && !late_q && acc_q == tmout_q) begin
              ev_rdtmo_q <= 1'b1;
              late_q <= 1'b1;
            end
          end
          S_DATA: if (cclk_r) begin
            word_q <= {word_q[30:0], dat0_s};
            wbit_q <= wbit_q + 5'h1;
            blk_q <= blk_q + 19'h1;
            if (wbit_q == 5'h1F) begin
              push_q <= 1'b1;
              push_data_q <= {word_q[30:0], dat0_s};
            end
            if (blk_q == blk_last) begin
              st_q <= S_CRC;
              bit_q <= 6'h0;
              rxb_q <= rxb_q + {16'h0, blksiz_q};
            end
          end
          S_CRC: if (cclk_r) begin
            bit_q <= bit_q + 6'h1;
            if (bit_q == `EBH_DCRC_LAST) begin
              ev_eerr_q <= ~dat0_s;
              if (rxb_q >= bytcnt_q) begin
                st_q <= S_IDLE;
                boot_q <= 1'b0;
                xend_q <= 1'b1;
                ev_done_q <= 1'b1;
                ev_over_q <= 1'b1;
              end else begin
                st_q <= S_WST;
                acc_q <= 24'h0;
                first_q <= 1'b0;
              end
            end
          end
          default: st_q <= S_IDLE;
        endcase
      end
    end
  end

  // Receive FIFO and descriptor DMA
  always @(posedge mclk) begin
    if (sys_rst) begin
      wp_q <= 4'h0;
      rp_q <= 4'h0;
      lvl_q <= 5'h0;
      off_q <= 9'h0;
      dclosed_q <= 16'h0;
      dma_wr_valid <= 1'b0;
      dma_wr_addr <= 32'h0;
      dma_wr_data <= 32'h0;
      {rxd_pend_q, ev_rxd_q, ev_unav_q} <= 3'h0;
    end else begin
      {ev_rxd_q, ev_unav_q} <= 2'h0;
      if (push_ok) begin
        wp_q <= wp_q + 4'h1;
      end
      if (pop) begin
        rp_q <= rp_q + 4'h1;
      end
      if (push_ok && !pop) begin
        lvl_q <= lvl_q + 5'h1;
      end else if (pop && !push_ok) begin
        lvl_q <= lvl_q - 5'h1;
      end
      if (dma_wr_valid && dma_wr_ready) begin
        dma_wr_valid <= 1'b0;
      end
      if (drst_q) begin
        dclosed_q <= 16'h0;
        off_q <= 9'h0;
      end else if (ev_tmo_q && use_dma && desc_ok) begin
        dclosed_q <= dclosed_q + 16'h1;
        off_q <= 9'h0;
      end else if (rxd_pend_q && lvl_q == 5'h0 && !dma_wr_valid && off_q != 9'h0) begin
        // Partly filled last buffer is handed back once the data is out
        dclosed_q <= dclosed_q + 16'h1;
        off_q <= 9'h0;
      end else if (dma_pop) begin
        if (desc_ok) begin
          dma_wr_valid <= 1'b1;
          dma_wr_addr <= dbase_q + {7'h0, dclosed_q, off_q};
          dma_wr_data <= ram_rdata;
          off_q <= off_q + 9'h4;
          if (off_q == `EBH_DESC_LAST) begin
            dclosed_q <= dclosed_q + 16'h1;
          end
        end else begin
          ev_unav_q <= 1'b1;
        end
      end
      if (cmd_go_q) begin
        rxd_pend_q <= 1'b0;
      end else if (ev_over_q && use_dma) begin
        rxd_pend_q <= 1'b1;
      end else if (rxd_pend_q && lvl_q == 5'h0 && !dma_wr_valid) begin
        rxd_pend_q <= 1'b0;
        ev_rxd_q <= 1'b1;
      end
    end
  end
endmodule // ebh_boot

// ==== sim/ebh_boot_assertions.sv ====
module ebh_boot_chk (
  // Clock and reset
  input wire logic        mclk,
  input wire logic        sys_rst,
  // Register bus
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic        avs_waitrequest,
  // Card link
  input wire logic        card_clk,
  input wire logic        cmd_out,
  input wire logic        cmd_oe_n,
  // DMA
  input wire logic        dma_wr_valid,
  input wire logic [31:0] dma_wr_addr,
  input wire logic [31:0] dma_wr_data,
  input wire logic        dma_wr_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] ck_q;
  logic [5:0] fall_q;
  // Own sync of the card clock, so a slip in the design's sync still shows
  always @(posedge mclk) begin
    if (sys_rst) begin
      ck_q   <= 3'h0;
      fall_q <= 6'h00;
    end else begin
      ck_q <= {ck_q[1:0], card_clk};
      if (cmd_oe_n)
        fall_q <= 6'h00;
      else if (ck_q[2:1] == 2'h2)
        fall_q <= fall_q + 6'h01;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  a_wait_two: assert property ($rose(avs_read || avs_write) |=> avs_waitrequest ##1 !avs_waitrequest)
    else $error("answer not two cycles after request");
  a_wait_one: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low longer than one cycle");
  a_wait_req: assert property (!avs_waitrequest |-> avs_read || avs_write)
    else $error("waitrequest low without request");
  a_dma_hold: assert property (dma_wr_valid && !dma_wr_ready |=> dma_wr_valid && $stable(dma_wr_addr) && $stable(dma_wr_data))
    else $error("dma write changed before ready");
  a_dma_align: assert property (dma_wr_valid |-> dma_wr_addr[1:0] == 2'h0)
    else $error("dma address not word aligned");
  a_cmd_start: assert property ($fell(cmd_oe_n) |-> !cmd_out)
    else $error("command frame without start bit");
  a_cmd_idle: assert property (cmd_oe_n |-> cmd_out)
    else $error("command line not released high");
  a_cmd_len: assert property ($rose(cmd_oe_n) |-> fall_q >= 6'h2E && fall_q <= 6'h31)
    else $error("command frame length wrong");
endmodule // ebh_boot_chk

bind ebh_boot ebh_boot_chk u_ebh_boot_chk (.mclk(mclk), .sys_rst(sys_rst), .avs_read(avs_read),
  .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .card_clk(card_clk),
  .cmd_out(cmd_out), .cmd_oe_n(cmd_oe_n), .dma_wr_valid(dma_wr_valid),
  .dma_wr_addr(dma_wr_addr), .dma_wr_data(dma_wr_data), .dma_wr_ready(dma_wr_ready));

// ==== sim/ebh_card_model.sv ====
module ebh_card_model (
  // Link
  input  wire logic        card_clk,
  input  wire logic        cmd_line,
  output logic             dat0,
  // Behaviour
  input  wire logic [1:0]  ack_mode,
  input  wire logic [3:0]  nblk,
  input  wire logic [7:0]  gap,
  input  wire logic [31:0] pat,
  // Observation
  output logic             busy,
  output logic [7:0]       frames,
  output logic [5:0]       last_idx,
  output logic [31:0]      last_arg
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [47:0] sh;
  logic [31:0] wd;
  logic [4:0]  ack;
  int          k;
  int          b;
  task automatic put(input logic v);
    @(negedge card_clk);
    dat0 = v;
  endtask
  initial begin
    {dat0, busy, frames, last_idx, last_arg} = {1'b1, 47'h0};
    forever begin
      @(posedge card_clk);
      if (cmd_line === 1'b0) begin
        for (k = 0; k < 47; k++) begin
          @(posedge card_clk);
          sh = {sh[46:0], cmd_line};
        end
        last_idx = sh[45:40];
        last_arg = sh[39:8];
        frames = frames + 8'h01;
        // Boot argument starts the boot answer; any other argument, such as zero, is only counted
        if (sh[39:8] == 32'hFFFFFFFA) begin
          busy = 1'b1;
          repeat (4) put(1'b1);
          // Mode 2 spoils the acknowledge pattern
          ack = {1'b0, (ack_mode == 2'h1) ? 3'h2 : 3'h6, 1'b1};
          for (k = 4; k >= 0 && ack_mode != 2'h0; k--)
            put(ack[k]);
          for (b = 0; b < nblk; b++) begin
            repeat (gap) put(1'b1);
            put(1'b0);
            for (k = 0; k < 64; k++) begin
              wd = pat ^ (b * 2 + k / 32);
              put(wd[31 - k % 32]);
            end
            // No CRC is modelled; the block carries no CRC error flag
            repeat (16) put(1'b0);
            put(1'b1);
          end
          busy = 1'b0;
        end
      end
    end
  end
endmodule // ebh_card_model

// ==== sim/tb_ebh_boot.sv ====
module tb_ebh_boot;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk, sys_rst, avs_read, avs_write, card_clk, dat0_in, dma_wr_ready;
  logic        avs_waitrequest, cmd_out, cmd_oe_n, dma_wr_valid, busy;
  logic [5:0]  avs_address, last_idx;
  logic [31:0] avs_writedata, avs_readdata, dma_wr_addr, dma_wr_data, pat, q, dbase, last_arg;
  logic [1:0]  ack_mode;
  logic [3:0]  nblk;
  logic [7:0]  gap, frames;
  logic [63:0] dq[$];
  integer      seed;
  int          n_errors, cmp_count, cyc, i;
  logic [5:0]  ra[6] = '{6'h00, 6'h0C, 6'h10, 6'h14, 6'h20, 6'h3C};
  logic [31:0] rv[6] = '{32'h0, 32'hFFFFFF, 32'h200, 32'h200, 32'h8, 32'h0};
  // CMD has a pull-up: released line reads high
  wire         cmd_line = cmd_oe_n ? 1'b1 : cmd_out;

  ebh_boot #(.ACK_TMO_CYC(25'h7D0), .DST_ACK_TMO_CYC(25'hFA0), .DST_TMO_CYC(25'hFA0)) u_ebh_boot (
    .mclk(mclk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .card_clk(card_clk), .cmd_in(cmd_line),
    .cmd_out(cmd_out), .cmd_oe_n(cmd_oe_n), .dat0_in(dat0_in), .dma_wr_valid(dma_wr_valid),
    .dma_wr_addr(dma_wr_addr), .dma_wr_data(dma_wr_data), .dma_wr_ready(dma_wr_ready));
  ebh_card_model u_ebh_card_model (.card_clk(card_clk), .cmd_line(cmd_line), .dat0(dat0_in),
    .ack_mode(ack_mode), .nblk(nblk), .gap(gap), .pat(pat), .busy(busy), .frames(frames),
    .last_idx(last_idx), .last_arg(last_arg));

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  initial begin
    card_clk = 1'b0;
    #7;
    forever #160 card_clk = ~card_clk;
  end
  // Memory side stalls at random and records every accepted write
  always @(posedge mclk) begin
    dma_wr_ready <= $random(seed);
    if (dma_wr_valid === 1'b1 && dma_wr_ready === 1'b1)
      dq.push_back({dma_wr_addr, dma_wr_data});
    cyc <= cyc + 1;
    if (cyc == 32'hEA60) begin
      n_errors++;
      end_sim;
    end
  end

  task end_sim;
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One register access; request held until waitrequest is sampled low
  task bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    do begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 40);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n == 40)
      n_errors++;
    @(posedge mclk);
  endtask
  task wt(input logic [5:0] a, input int b);
    int n;
    n = 0;
    do begin
      bus(1'b0, a, 32'h0);
      n++;
    end while (q[b] !== 1'b1 && n < 3000);
    if (q[b] !== 1'b1)
      n_errors++;
  endtask
  task drain(input int nw);
    int got, n, j, lv;
    got = 0;
    n = 0;
    while (got < nw && n < 2000) begin
      n++;
      bus(1'b0, 6'h18, 32'h0);
      if (q[4] | q[3]) begin
        bus(1'b0, 6'h24, 32'h0);
        lv = q[7:3];
        for (j = 0; j < lv; j++) begin
          bus(1'b0, 6'h28, 32'h0);
          chk("fifo word", pat ^ got, q);
          got++;
        end
        bus(1'b1, 6'h18, 32'h10);
      end
    end
    chk("fifo count", nw, got);
  endtask
  task boot(input logic ack, input logic dma, input logic [31:0] dc, input logic [3:0] nb,
            input logic [1:0] am);
    ack_mode <= am;
    nblk <= nb;
    pat <= $random(seed);
    dbase = $random(seed) & 32'hFFFFF000;
    bus(1'b1, 6'h18, 32'hFFFFFFFF);
    bus(1'b1, 6'h1C, 32'hFFFFFFFF);
    bus(1'b1, 6'h2C, dbase);
    bus(1'b1, 6'h30, dc);
    bus(1'b1, 6'h00, {30'h0, dma, 1'b1});
    // Short blocks keep the run brief; the block logic is the same
    bus(1'b1, 6'h10, 32'h8);
    bus(1'b1, 6'h14, 32'h10);
    bus(1'b1, 6'h20, 32'h2);
    bus(1'b1, 6'h08, 32'hFFFFFFFA);
    bus(1'b1, 6'h04, {1'b1, 5'h0, ack, 1'b1, 14'h0, 1'b1, 9'h0});
  endtask
  task term;
    int n;
    logic [7:0] f;
    n = 0;
    while (busy === 1'b1 && n < 9000) begin
      @(posedge mclk);
      n++;
    end
    f = frames;
    bus(1'b1, 6'h08, 32'h0);
    bus(1'b1, 6'h04, 32'h80000000);
    while (frames == f && n < 9000) begin
      @(posedge mclk);
      n++;
    end
    chk("end arg", 32'h0, last_arg);
    chk("end index", 32'h0, {26'h0, last_idx});
  endtask

  initial begin
    seed = 32'hD061;
    {sys_rst, avs_read, avs_write, avs_address, avs_writedata} = {3'h4, 38'h0};
    {ack_mode, nblk, gap, pat, n_errors, cmp_count} = 0;
    repeat (6) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    bus(1'b1, 6'h3C, 32'hFFFFFFFF);
    for (i = 0; i < 6; i++) begin
      bus(1'b0, ra[i], 32'h0);
      chk("reset reg", rv[i], q);
    end
    // At least 74 card clocks must pass before the first boot command
    repeat (600) @(posedge mclk);
    gap <= 8'h04;
    boot(1'b1, 1'b0, 32'h3, 4'h2, 2'h1);
    wt(6'h18, 16);
    bus(1'b1, 6'h18, 32'h10000);
    bus(1'b0, 6'h18, 32'h0);
    chk("ack cleared", 32'h0, q[16]);
    drain(4);
    wt(6'h18, 3);
    chk("done flags", 32'hC, q & 32'hC);
    bus(1'b0, 6'h1C, 32'h0);
    chk("rx done fifo", 32'h0, q[1]);
    chk("boot arg", 32'hFFFFFFFA, last_arg);
    term;
    dq.delete();
    boot(1'b0, 1'b1, 32'h3, 4'h2, 2'h0);
    wt(6'h1C, 1);
    chk("dma count", 32'h4, dq.size());
    foreach (dq[j]) begin
      chk("dma addr", dbase + 4 * j, dq[j][63:32]);
      chk("dma data", pat ^ j, dq[j][31:0]);
    end
    bus(1'b0, 6'h18, 32'h0);
    chk("done flags", 32'hC, q & 32'hC);
    bus(1'b0, 6'h34, 32'h0);
    chk("closed", 32'h1, q);
    term;
    boot(1'b1, 1'b1, 32'h3, 4'h0, 2'h0);
    wt(6'h1C, 5);
    chk("rx done", 32'h0, q[1]);
    bus(1'b0, 6'h34, 32'h0);
    chk("closed", 32'h1, q);
    boot(1'b1, 1'b1, 32'h3, 4'h0, 2'h1);
    wt(6'h1C, 5);
    chk("card err", 32'h1, q[5]);
    chk("rx done", 32'h0, q[1]);
    boot(1'b0, 1'b1, 32'h3, 4'h0, 2'h0);
    wt(6'h1C, 5);
    chk("card err", 32'h1, q[5]);
    chk("rx done", 32'h0, q[1]);
    bus(1'b0, 6'h34, 32'h0);
    chk("closed", 32'h1, q);
    boot(1'b1, 1'b0, 32'h3, 4'h2, 2'h2);
    wt(6'h18, 17);
    chk("ack flag", 32'h0, q[16]);
    drain(4);
    term;
    gap <= 8'h3C;
    bus(1'b1, 6'h0C, 32'h10);
    boot(1'b0, 1'b0, 32'h3, 4'h2, 2'h0);
    wt(6'h18, 9);
    chk("read timeout", 32'h1, q[9]);
    // Empty the FIFO so no stale words reach the next DMA run
    drain(4);
    term;
    gap <= 8'h04;
    dq.delete();
    boot(1'b0, 1'b1, 32'h0, 4'h2, 2'h0);
    wt(6'h1C, 4);
    chk("desc unavail", 32'h1, q[4]);
    term;
    chk("no dma writes", 32'h0, dq.size());
    end_sim;
  end
endmodule // tb_ebh_boot
